// ===== rtl/cpx_top.v
`timescale 1ns/1ns
`include "cpx_defines.vh"
module cpx_top #(
  parameter NPIN = 7
) (
  // clock and reset
  input wire clk_in,
  input wire rstn_in,
  // register port
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  // camera side
  input wire cam_pclk_in,
  input wire cam_href_in,
  input wire [19:0] camera_data_lines_in,
  // captured pixels
  output reg pix_valid_out,
  output reg [29:0] pix_data_out,
  input wire pix_ready_in,
  // display side
  output reg screen_clk_out,
  output reg [NPIN-1:0] sync_pin_out,
  output reg [NPIN-1:0] async_pin_out,
  output reg panel_select_zero_n_out,
  output reg panel_select_one_n_out,
  output reg [15:0] disp_data_out
);
  function [3:0] fmt_cycles;
    input [3:0] f;
    begin
      case (f)
        `CPX_F_565X2, `CPX_F_YC8X2: fmt_cycles = 4'h2;
        `CPX_F_565X3, `CPX_F_666X3, `CPX_F_888X3: fmt_cycles = 4'h3;
        default: fmt_cycles = 4'h1;
      endcase
    end
  endfunction

  function in_win(input [15:0] c, input [15:0] lo, input [15:0] hi);
    in_win = (c >= lo) && (c < hi);
  endfunction

  // registers
  reg [5:0] ctrl_r;
  reg ovr_r;
  reg [31:0] line_r;
  reg [15:0] dclk_r;
  reg [15:0] alen_r;
  reg [31:0] spin_r [0:NPIN-1];
  reg [31:0] apin_r [0:NPIN-1];
  reg [15:0] pcnt_r;
  wire [3:0] fmt;
  assign fmt = ctrl_r[`CPX_CTRL_FMT];

  // camera pin synchronisers
  reg [2:0] pclk_s_r;
  reg [2:0] href_s_r;
  reg [19:0] d1_r;
  reg [19:0] d2_r;
  reg [19:0] d3_r;
  reg pclk_lvl_r;
  wire pclk_rise;
  assign pclk_rise = (pclk_s_r[1] == pclk_s_r[2]) && pclk_s_r[2] && !pclk_lvl_r;

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pclk_s_r <= 3'h0;
      href_s_r <= 3'h0;
      d1_r <= 20'h0_0000;
      d2_r <= 20'h0_0000;
      d3_r <= 20'h0_0000;
      pclk_lvl_r <= 1'b0;
    end else begin
      pclk_s_r <= {pclk_s_r[1:0], cam_pclk_in};
      href_s_r <= {href_s_r[1:0], cam_href_in};
      d1_r <= camera_data_lines_in;
      d2_r <= d1_r;
      d3_r <= d2_r;
      if (pclk_s_r[1] == pclk_s_r[2])
        pclk_lvl_r <= pclk_s_r[2];
    end
  end

  // pixel assembly
  reg [3:0] cyc_r;
  reg [7:0] p0_r;
  reg [7:0] p1_r;
  reg asm_vld_r;
  reg [29:0] asm_pix_r;
  reg [29:0] pix_nxt;
  wire [7:0] b;
  wire smp;
  wire last;
  wire buf_in_rdy;
  wire buf_vld;
  wire [29:0] buf_dat;
  assign b = d3_r[19:12];
  assign smp = pclk_rise && href_s_r[2] && ctrl_r[`CPX_CTRL_CEN];
  assign last = (cyc_r == fmt_cycles(fmt) - 4'h1);

  always @* begin
    pix_nxt = 30'h0000_0000;
    case (fmt)
      `CPX_F_565X2: begin
        pix_nxt[24:20] = b[7:3];
        pix_nxt[15:10] = {b[2:0], p0_r[7:5]};
        pix_nxt[4:0] = p0_r[4:0];
      end
      `CPX_F_565X3: begin
        pix_nxt[24:20] = p0_r[7:3];
        pix_nxt[15:10] = p1_r[7:2];
        pix_nxt[4:0] = b[7:3];
      end
      `CPX_F_666X3: begin
        pix_nxt[25:20] = p0_r[7:2];
        pix_nxt[15:10] = p1_r[7:2];
        pix_nxt[5:0] = b[7:2];
      end
      `CPX_F_888X3: begin
        pix_nxt[27:20] = p0_r;
        pix_nxt[17:10] = p1_r;
        pix_nxt[7:0] = b;
      end
      `CPX_F_YC8X2: begin
        pix_nxt[17:10] = b;
        pix_nxt[7:0] = p0_r;
      end
      `CPX_F_565X1: begin
        pix_nxt[24:20] = d3_r[19:15];
        pix_nxt[15:10] = d3_r[14:9];
        pix_nxt[4:0] = d3_r[8:4];
      end
      `CPX_F_YC16A: begin
        pix_nxt[17:10] = d3_r[19:12];
        pix_nxt[7:0] = d3_r[11:4];
      end
      `CPX_F_YC16B: begin
        pix_nxt[17:10] = d3_r[19:12];
        pix_nxt[7:0] = d3_r[9:2];
      end
      `CPX_F_YC20: begin
        pix_nxt[19:10] = d3_r[19:10];
        pix_nxt[9:0] = d3_r[9:0];
      end
      default: pix_nxt = 30'h0000_0000;
    endcase
  end

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cyc_r <= 4'h0;
      p0_r <= 8'h00;
      p1_r <= 8'h00;
      asm_vld_r <= 1'b0;
      asm_pix_r <= 30'h0000_0000;
    end else begin
      asm_vld_r <= 1'b0;
      if (!href_s_r[2] || !ctrl_r[`CPX_CTRL_CEN]) begin
        cyc_r <= 4'h0;
      end else if (smp) begin
        if (cyc_r == 4'h0)
          p0_r <= b;
        if (cyc_r == 4'h1)
          p1_r <= b;
        if (last) begin
          cyc_r <= 4'h0;
          asm_vld_r <= 1'b1;
          asm_pix_r <= pix_nxt;
        end else begin
          cyc_r <= cyc_r + 4'h1;
        end
      end
    end
  end

  cpx_buf2 #(
    .W(30)
  ) u_buf (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .in_valid_in(asm_vld_r),
    .in_data_in(asm_pix_r),
    .in_ready_out(buf_in_rdy),
    .out_valid_out(buf_vld),
    .out_data_out(buf_dat),
    .out_ready_in(!pix_valid_out || pix_ready_in)
  );

  // output stage so the pixel port comes from flops
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pix_valid_out <= 1'b0;
      pix_data_out <= 30'h0000_0000;
    end else if (!pix_valid_out || pix_ready_in) begin
      pix_valid_out <= buf_vld;
      pix_data_out <= buf_dat;
    end
  end

  // screen-port timing: one clk is half a screen-port clock
  reg sp_ph_r;
  reg [15:0] hcnt_r;
  reg [15:0] vcnt_r;
  reg [15:0] dcnt_r;
  wire den;
  wire line_end;
  assign den = ctrl_r[`CPX_CTRL_DEN];
  assign line_end = (hcnt_r >= line_r[15:0] - 16'h0001) && sp_ph_r;

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sp_ph_r <= 1'b0;
      hcnt_r <= 16'h0000;
      vcnt_r <= 16'h0000;
      dcnt_r <= 16'h0000;
      screen_clk_out <= 1'b0;
    end else if (!den) begin
      sp_ph_r <= 1'b0;
      hcnt_r <= 16'h0000;
      vcnt_r <= 16'h0000;
      dcnt_r <= 16'h0000;
      screen_clk_out <= 1'b0;
    end else begin
      sp_ph_r <= ~sp_ph_r;
      if (line_end) begin
        hcnt_r <= 16'h0000;
        if (vcnt_r >= line_r[31:16] - 16'h0001)
          vcnt_r <= 16'h0000;
        else
          vcnt_r <= vcnt_r + 16'h0001;
      end else begin
        hcnt_r <= hcnt_r + 16'h0001;
      end
      if (line_end || dcnt_r >= dclk_r - 16'h0001) begin
        dcnt_r <= 16'h0000;
        screen_clk_out <= !line_end && !screen_clk_out;
      end else begin
        dcnt_r <= dcnt_r + 16'h0001;
      end
    end
  end

  // synchronous control pins
  integer i, j, k, n;
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync_pin_out <= {NPIN{1'b0}};
    end else begin
      for (i = 0; i < NPIN; i = i + 1) begin
        sync_pin_out[i] <= den && in_win(spin_r[i][31] ? {1'b0, vcnt_r[14:0]} :
          {1'b0, hcnt_r[14:0]}, {1'b0, spin_r[i][14:0]}, {1'b0, spin_r[i][29:15]});
      end
    end
  end

  // asynchronous data engine
  reg abusy_r;
  reg [15:0] acnt_r;
  reg [NPIN-1:0] aflg_r;
  wire adat_wr;
  assign adat_wr = reg_wr_in && (reg_addr_in == `CPX_A_ADAT) && !abusy_r;

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      abusy_r <= 1'b0;
      acnt_r <= 16'h0000;
      aflg_r <= {NPIN{1'b0}};
      disp_data_out <= 16'h0000;
      panel_select_zero_n_out <= 1'b1;
      panel_select_one_n_out <= 1'b1;
      async_pin_out <= {NPIN{1'b0}};
    end else begin
      if (adat_wr) begin
        abusy_r <= 1'b1;
        acnt_r <= 16'h0000;
        disp_data_out <= reg_wdata_in[15:0];
        aflg_r <= reg_wdata_in[23:17];
        panel_select_zero_n_out <= reg_wdata_in[16];
        panel_select_one_n_out <= !reg_wdata_in[16];
      end else if (abusy_r) begin
        if (acnt_r >= alen_r - 16'h0001) begin
          abusy_r <= 1'b0;
          panel_select_zero_n_out <= 1'b1;
          panel_select_one_n_out <= 1'b1;
        end else begin
          acnt_r <= acnt_r + 16'h0001;
        end
      end
      for (j = 0; j < NPIN; j = j + 1)
        async_pin_out[j] <= abusy_r && !adat_wr && aflg_r[j] &&
          in_win(acnt_r, apin_r[j][15:0], apin_r[j][31:16]);
    end
  end

  // register writes
  wire ovr_set;
  assign ovr_set = asm_vld_r && !buf_in_rdy;
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_r <= 6'h00;
      ovr_r <= 1'b0;
      line_r <= `CPX_RST_LINE;
      dclk_r <= `CPX_RST_DCLK;
      alen_r <= `CPX_RST_ALEN;
      pcnt_r <= 16'h0000;
      for (k = 0; k < NPIN; k = k + 1) begin
        spin_r[k] <= 32'h0000_0000;
        apin_r[k] <= 32'h0000_0000;
      end
    end else begin
      if (asm_vld_r && buf_in_rdy)
        pcnt_r <= pcnt_r + 16'h0001;
      // set wins over a same-cycle clear
      if (ovr_set)
        ovr_r <= 1'b1;
      else if (reg_wr_in && reg_addr_in == `CPX_A_STAT && reg_wdata_in[`CPX_STAT_OVR])
        ovr_r <= 1'b0;
      if (reg_wr_in) begin
        case (reg_addr_in)
          `CPX_A_CTRL: ctrl_r <= reg_wdata_in[5:0];
          `CPX_A_LINE: line_r <= reg_wdata_in;
          `CPX_A_DCLK: dclk_r <= reg_wdata_in[15:0];
          `CPX_A_ALEN: alen_r <= reg_wdata_in[15:0];
          default: ;
        endcase
        for (k = 0; k < NPIN; k = k + 1) begin
          if (reg_addr_in == `CPX_A_SPIN + 8'h04 * k[7:0])
            spin_r[k] <= reg_wdata_in;
          if (reg_addr_in == `CPX_A_APIN + 8'h04 * k[7:0])
            apin_r[k] <= reg_wdata_in;
        end
      end
    end
  end

  // register reads, one cycle later; unmapped reads zero
  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (reg_addr_in)
      `CPX_A_CTRL: rd_nxt = {26'h000_0000, ctrl_r};
      `CPX_A_STAT: rd_nxt = {30'h0000_0000, abusy_r, ovr_r};
      `CPX_A_LINE: rd_nxt = line_r;
      `CPX_A_DCLK: rd_nxt = {16'h0000, dclk_r};
      `CPX_A_ALEN: rd_nxt = {16'h0000, alen_r};
      `CPX_A_PCNT: rd_nxt = {16'h0000, pcnt_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
    for (n = 0; n < NPIN; n = n + 1) begin
      if (reg_addr_in == `CPX_A_SPIN + 8'h04 * n[7:0])
        rd_nxt = spin_r[n];
      if (reg_addr_in == `CPX_A_APIN + 8'h04 * n[7:0])
        rd_nxt = apin_r[n];
    end
  end

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (reg_rd_in)
      reg_rdata_out <= rd_nxt;
    else
      reg_rdata_out <= 32'h0000_0000;
  end
endmodule

// ===== rtl/cpx_defines.vh
// What this block does
// - rgb565 two cycles on lines 12-19: blue and low green, then high green and red
// - rgb565 three cycles: red, green, blue, each on lines 12-19
// - rgb666 three cycles: each component's bits on lines 14-19
// - rgb888 three cycles: each full component on lines 12-19
// - 8-bit luma/chroma, two cycles, one sample each on lines 12-19
// - rgb565 one cycle on lines 4-19, lines 0-3 unused
// - 16-bit luma/chroma: chroma on lines 4-11, luma on 12-19
// - 16-bit variant: chroma on lines 2-9, luma on 12-19, others zero
// - 20-bit luma/chroma: chroma on lines 0-9, luma on 10-19
// - drive a dedicated display base clock output
// - seven general purpose synchronous control pins, each freely assigned
// - binding counters make local start points aligned to screen-port clock
// - sync controls placed from start point by up/down values, half-clock steps
// - asynchronous controls change together with the output data word
// - two chip-select outputs, one per attached display
// - seven general purpose asynchronous pins, each freely assigned
// - each async data word written while not busy makes a start point; pins toggle at up/down
`ifndef CPX_DEFINES_VH
`define CPX_DEFINES_VH
`define CPX_A_CTRL 8'h00
`define CPX_A_STAT 8'h04
`define CPX_A_LINE 8'h08
`define CPX_A_DCLK 8'h0C
`define CPX_A_ALEN 8'h10
`define CPX_A_ADAT 8'h14
`define CPX_A_PCNT 8'h18
`define CPX_A_SPIN 8'h20
`define CPX_A_APIN 8'h40
`define CPX_CTRL_FMT 3:0
`define CPX_CTRL_CEN 4
`define CPX_CTRL_DEN 5
`define CPX_STAT_OVR 0
`define CPX_STAT_ABSY 1
`define CPX_RST_LINE 32'h0001_0020
`define CPX_RST_DCLK 16'h0002
`define CPX_RST_ALEN 16'h0008
`define CPX_F_565X2 4'h0
`define CPX_F_565X3 4'h1
`define CPX_F_666X3 4'h2
`define CPX_F_888X3 4'h3
`define CPX_F_YC8X2 4'h4
`define CPX_F_565X1 4'h5
`define CPX_F_YC16A 4'h6
`define CPX_F_YC16B 4'h7
`define CPX_F_YC20 4'h8
`endif

// ===== rtl/cpx_buf2.v
`timescale 1ns/1ns
module cpx_buf2 #(
  parameter W = 30
) (
  // clock and reset
  input wire clk_in,
  input wire rstn_in,
  // fill side
  input wire in_valid_in,
  input wire [W-1:0] in_data_in,
  output wire in_ready_out,
  // drain side
  output wire out_valid_out,
  output wire [W-1:0] out_data_out,
  input wire out_ready_in
);
  reg [W-1:0] mem_r [0:1];
  reg rd_r;
  reg wr_r;
  reg [1:0] cnt_r;
  wire push;
  wire pop;

  assign in_ready_out = (cnt_r != 2'h2);
  assign out_valid_out = (cnt_r != 2'h0);
  assign out_data_out = mem_r[rd_r];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      cnt_r <= 2'h0;
      mem_r[0] <= {W{1'b0}};
      mem_r[1] <= {W{1'b0}};
    end else begin
      if (push) begin
        mem_r[wr_r] <= in_data_in;
        wr_r <= ~wr_r;
      end
      if (pop)
        rd_r <= ~rd_r;
      if (push && !pop)
        cnt_r <= cnt_r + 2'h1;
      else if (pop && !push)
        cnt_r <= cnt_r - 2'h1;
    end
  end
endmodule

// ===== tb/cpx_properties.sv
`timescale 1ns/1ns
`include "cpx_defines.vh"
module cpx_properties #(
  parameter NPIN = 7
) (
  // clock, reset, register port
  input wire clk_in,
  input wire rstn_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [31:0] reg_rdata_out,
  // pixels and display
  input wire pix_valid_out,
  input wire [29:0] pix_data_out,
  input wire pix_ready_in,
  input wire screen_clk_out,
  input wire [NPIN-1:0] sync_pin_out,
  input wire [NPIN-1:0] async_pin_out,
  input wire panel_select_zero_n_out,
  input wire panel_select_one_n_out,
  input wire [15:0] disp_data_out
);
  reg den_r;
  reg [15:0] dclk_r;
  reg [15:0] alen_r;
  wire sel_w = !panel_select_zero_n_out || !panel_select_one_n_out;
  // shadow of the settings that shape the outputs
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      den_r <= 1'b0;
      dclk_r <= `CPX_RST_DCLK;
      alen_r <= `CPX_RST_ALEN;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `CPX_A_CTRL) den_r <= reg_wdata_in[`CPX_CTRL_DEN];
      if (reg_addr_in == `CPX_A_DCLK) dclk_r <= reg_wdata_in[15:0];
      if (reg_addr_in == `CPX_A_ALEN) alen_r <= reg_wdata_in[15:0];
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside a read reply");
  one_panel_a: assert property (sel_w |-> panel_select_zero_n_out || panel_select_one_n_out)
    else $error("both panels selected");
  data_with_word_a: assert property ($changed(disp_data_out) && den_r |-> sel_w && !$past(sel_w))
    else $error("output word changed without a new select");
  pins_in_word_a: assert property (|async_pin_out |-> $past(sel_w) || $past(sel_w, 2))
    else $error("async pin active outside a word");
  select_hold_a: assert property ($fell(panel_select_zero_n_out) && den_r && alen_r == 16'h0008
    |-> !panel_select_zero_n_out [*8] ##1 panel_select_zero_n_out)
    else $error("select low time wrong");
  pix_hold_a: assert property (pix_valid_out && !pix_ready_in |=> pix_valid_out && $stable(pix_data_out))
    else $error("pixel dropped or changed while stalled");
  idle_display_a: assert property (!den_r [*2] |-> !screen_clk_out && sync_pin_out == {NPIN{1'b0}})
    else $error("display active while disabled");
  screen_clk_a: assert property (den_r && dclk_r == 16'h0002 && $fell(screen_clk_out) |=> !screen_clk_out)
    else $error("screen clock low phase too short");
  cover property (pix_valid_out && pix_ready_in);
  cover property ($fell(panel_select_one_n_out));
  cover property ($rose(sync_pin_out[0]));
endmodule
bind cpx_top cpx_properties #(.NPIN(NPIN)) chk_u (.clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .pix_valid_out, .pix_data_out, .pix_ready_in,
  .screen_clk_out, .sync_pin_out, .async_pin_out, .panel_select_zero_n_out,
  .panel_select_one_n_out, .disp_data_out);

// ===== tb/cpx_cam_model.sv
`timescale 1ns/1ns
module cpx_cam_model (
  // camera pins
  output reg cam_pclk_out,
  output reg cam_href_out,
  output reg [19:0] cam_data_out
);
  initial begin
    cam_pclk_out = 1'b0;
    cam_href_out = 1'b0;
    cam_data_out = 20'h0;
  end
  // pixel clock runs only inside a line
  task send(input [59:0] w, input [1:0] n);
    integer i;
    begin
      cam_href_out <= 1'b1;
      for (i = 0; i < n; i = i + 1) begin
        cam_data_out <= w[i*20 +: 20];
        #40 cam_pclk_out <= 1'b1;
        #40 cam_pclk_out <= 1'b0;
      end
      #40 cam_href_out <= 1'b0;
      cam_data_out <= ~cam_data_out;
      #80;
    end
  endtask
endmodule

// ===== tb/cpx_top_tb.sv
`timescale 1ns/1ns
`include "cpx_defines.vh"
module cpx_top_tb;
  reg clk_in = 1'b0;
  reg rstn_in = 1'b0;
  reg [7:0] ra = 8'h00;
  reg [31:0] wd = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg rdy = 1'b0;
  reg [1:0] rm = 2'h0;
  reg [29:0] q [$];
  reg [29:0] p;
  reg [63:0] z;
  reg [61:0] e;
  reg [31:0] d;
  wire [31:0] rdat;
  wire [29:0] pd;
  wire [19:0] cdat;
  wire [15:0] dd;
  wire [6:0] sp, ap;
  wire pclk, href, pv, sck, s0n, s1n;
  integer seed = 32'h5a58;
  integer miscompares = 0;
  integer checks = 0;
  integer cyc = 0;
  integer f, k, i, nsel, nck;
  integer fs [0:6], ns [0:6], fa [0:6], na [0:6];
  cpx_top #(.NPIN(7)) dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(ra),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
    .cam_pclk_in(pclk), .cam_href_in(href), .camera_data_lines_in(cdat),
    .pix_valid_out(pv), .pix_data_out(pd), .pix_ready_in(rdy), .screen_clk_out(sck),
    .sync_pin_out(sp), .async_pin_out(ap), .panel_select_zero_n_out(s0n),
    .panel_select_one_n_out(s1n), .disp_data_out(dd));
  cpx_cam_model cam_u (.cam_pclk_out(pclk), .cam_href_out(href), .cam_data_out(cdat));
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) rdy <= (rm == 2'h1) ? 1'($random(seed)) : rm[1];
  always @(posedge clk_in) if (pv === 1'b1 && rdy === 1'b1) q.push_back(pd);
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      miscompares = miscompares + 1;
      stop_test;
    end
  end
  task stop_test;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] x, input [31:0] y);
    begin
      checks = checks + 1;
      if (y !== x) begin
        $display("wrong value %0s exp %0h got %0h", nm, x, y);
        miscompares = miscompares + 1;
      end
    end
  endtask
  task wrr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk_in);
      ra <= a;
      wd <= v;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
    end
  endtask
  task rchk(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk_in);
      ra <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1;
      chk("register", v, rdat);
    end
  endtask
  task take(input [29:0] x);
    integer t;
    begin
      t = 0;
      while (q.size() == 0 && t < 100) begin
        @(posedge clk_in);
        #1;
        t = t + 1;
      end
      chk("pixel", {2'h0, x}, q.size() != 0 ? {2'h0, q.pop_front()} : 32'hFFFFFFFF);
    end
  endtask
  // samples the display pins for 24 cycles after a write
  task watch;
    begin
      nsel = 0;
      nck = 0;
      for (i = 0; i < 7; i = i + 1) begin
        fs[i] = 0;
        ns[i] = 0;
        fa[i] = 0;
        na[i] = 0;
      end
      for (k = 1; k < 25; k = k + 1) begin
        if (k > 1) @(posedge clk_in);
        #1;
        nck = nck + (sck === 1'b1);
        nsel = nsel + (s0n === 1'b0);
        for (i = 0; i < 7; i = i + 1) begin
          if (sp[i] === 1'b1 && fs[i] == 0) fs[i] = k;
          if (ap[i] === 1'b1 && fa[i] == 0) fa[i] = k;
          ns[i] = ns[i] + (sp[i] === 1'b1);
          na[i] = na[i] + (ap[i] === 1'b1);
        end
      end
    end
  endtask
  function [61:0] enc(input [3:0] f, input [29:0] p, input [59:0] z);
    reg [19:0] a, b, c;
    reg [9:0] r, g, x;
    begin
      {c, b, a} = z;
      {r, g, x} = p;
      case (f)
        4'h0: begin a[19:12] = {g[2:0], x[4:0]}; b[19:12] = {r[4:0], g[5:3]}; end
        4'h1: begin a[19:12] = {r[4:0], r[4:2]}; b[19:12] = {g[5:0], g[5:4]};
          c[19:12] = {x[4:0], x[4:2]}; end
        4'h2: begin a[19:12] = {r[5:0], r[5:4]}; b[19:12] = {g[5:0], g[5:4]};
          c[19:12] = {x[5:0], x[5:4]}; end
        4'h3: begin a[19:12] = r[7:0]; b[19:12] = g[7:0]; c[19:12] = x[7:0]; end
        4'h4: begin a[19:12] = x[7:0]; b[19:12] = g[7:0]; end
        4'h5: a[19:4] = {r[4:0], g[5:0], x[4:0]};
        4'h6: a[19:4] = {g[7:0], x[7:0]};
        4'h7: a = {g[7:0], 2'h0, x[7:0], 2'h0};
        default: a = {g, x};
      endcase
      enc = {(f == 4'h0 || f == 4'h4) ? 2'h2 : (f < 4'h4) ? 2'h3 : 2'h1, c, b, a};
    end
  endfunction
  function [29:0] msk(input [3:0] f, input [29:0] p);
    case (f)
      4'h0, 4'h1, 4'h5: msk = p & {10'h1F, 10'h3F, 10'h1F};
      4'h2: msk = p & {3{10'h3F}};
      4'h3: msk = p & {3{10'hFF}};
      4'h4, 4'h6, 4'h7: msk = p & {10'h0, 10'hFF, 10'hFF};
      default: msk = p & {10'h0, 10'h3FF, 10'h3FF};
    endcase
  endfunction
  initial begin
    repeat (3) @(posedge clk_in);
    rstn_in <= 1'b1;
    rchk(`CPX_A_CTRL, 32'h0);
    rchk(`CPX_A_LINE, `CPX_RST_LINE);
    rchk(`CPX_A_DCLK, 32'h2);
    rchk(`CPX_A_ALEN, 32'h8);
    rchk(8'hFC, 32'h0);
    for (i = 0; i < 7; i = i + 1) wrr(8'(`CPX_A_SPIN + 4 * i), 32'((i + 4) << 15 | (i + 1)));
    wrr(`CPX_A_CTRL, 32'h20);
    watch;
    chk("screen clock", 32'h1, 32'(nck > 0 && nck < 24));
    for (i = 0; i < 7; i = i + 1) begin
      chk("sync offset", 32'(i), 32'(fs[i] - fs[0]));
      chk("sync width", 32'h3, 32'(ns[i]));
    end
    for (i = 0; i < 7; i = i + 1) wrr(8'(`CPX_A_APIN + 4 * i), 32'((i + 2) << 16 | i));
    d = $random(seed);
    wrr(`CPX_A_ADAT, {8'h0, 7'h7F, 1'b0, d[15:0]});
    watch;
    chk("word", {16'h0, d[15:0]}, {16'h0, dd});
    chk("select time", 32'h8, 32'(nsel));
    for (i = 0; i < 7; i = i + 1) begin
      chk("async start", 32'(i + 2), 32'(fa[i]));
      chk("async width", 32'h2, 32'(na[i]));
    end
    wrr(`CPX_A_ADAT, {15'h0, 1'b1, d[31:16]});
    wrr(`CPX_A_ADAT, {15'h0, 1'b0, ~d[31:16]});
    #1;
    chk("busy word", {16'h0, d[31:16]}, {16'h0, dd});
    chk("selects", 32'h1, {30'h0, s1n, s0n});
    rchk(`CPX_A_STAT, 32'h2);
    wrr(`CPX_A_SPIN, 32'h8000_8000);
    repeat (2) @(posedge clk_in);
    #1 d[0] = sp[0];
    @(posedge clk_in);
    #1;
    chk("line mode pin", 32'h3, {30'h0, d[0], sp[0]});
    repeat (10) @(posedge clk_in);
    rm = 2'h1;
    for (f = 0; f < 9; f = f + 1) begin
      wrr(`CPX_A_CTRL, 32'h30 | f);
      for (k = 0; k < 3; k = k + 1) begin
        p = 30'($random(seed));
        z = {$random(seed), $random(seed)};
        e = enc(f[3:0], p, z[59:0]);
        if (k == 0 && e[61:60] > 2'h1) cam_u.send(z[59:0], 2'h1);
        cam_u.send(e[59:0], e[61:60]);
        take(msk(f[3:0], p));
      end
    end
    rm = 2'h0;
    wrr(`CPX_A_CTRL, 32'h38);
    for (k = 1; k < 6; k = k + 1) cam_u.send(60'(k), 2'h1);
    repeat (8) @(posedge clk_in);
    rchk(`CPX_A_STAT, 32'h1);
    rchk(`CPX_A_PCNT, 32'h1E);
    wrr(`CPX_A_STAT, 32'h1);
    rchk(`CPX_A_STAT, 32'h0);
    rm = 2'h2;
    take(30'h1);
    take(30'h2);
    @(posedge clk_in);
    rstn_in <= 1'b0;
    #1;
    chk("reset outputs", 32'hC000_0000, {s1n, s0n, 14'h0, dd});
    stop_test;
  end
endmodule
